/* File: cfg_eeprom_model.sv */
// Behavioural serial EEPROM that sits on the loader's two-wire bus.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/1ns
module cfg_eeprom_model
    import startup_cfg_pkg::*;
(
    input wire logic scl, // Clock line level
    input wire logic sda, // Data line level
    input wire logic present, // Answers its address
    output logic sda_pull // High pulls data low
);
    logic [7:0] mem [32];
    logic [7:0] sh, ptr;
    logic rd = 0, act = 0, adr = 0, dat = 0;
    int bitc = 0;
    initial begin
        sda_pull = 0;
        foreach (mem[i]) mem[i] = 8'(i * 17);
        mem[0] = 8'hAA;
        mem[1] = 8'h55;
    end
    // Start and stop conditions
    always @(negedge sda) if (scl) {bitc, adr, rd, dat} = {32'd0, 3'b100};
    always @(posedge sda) if (scl) {act, adr} = 2'b00;
    // Sample; a master NACK ends the read
    always @(posedge scl) begin
        if (bitc < 8)
            sh = {sh[6:0], sda};
        else if (dat) begin
            ptr = ptr + 8'h01;
            act = act && !sda;
        end
        bitc = bitc + 1;
    end
    // Drive after the falling clock; released bits float high
    always @(negedge scl) begin
        sda_pull = 0;
        if (bitc == 8 && adr) begin
            adr = 0;
            act = present && sh[7:1] == DEV_ADDR_WR[7:1];
            rd = sh[0];
            sda_pull = act;
        end else if (bitc == 8 && act && !rd) begin
            ptr = sh;
            sda_pull = 1;
        end else if (bitc == 9) begin
            bitc = 0;
            dat = rd && act;
        end
        if (dat && bitc < 8)
            sda_pull = !mem[ptr[4:0]][7 - bitc];
    end
endmodule // cfg_eeprom_model

/* File: startup_cfg_pkg.sv */
// Constants for the start-up configuration loader: map byte offsets,
// field positions, signature, built-in maps and timing.
// Assumes a 10 MHz core clock and a 160 ns link clock.
package startup_cfg_pkg;
    // Signature and map offsets
    localparam logic [7:0] SIG_FIRST = 8'hAA;
    localparam logic [7:0] SIG_SECOND = 8'h55;
    localparam logic [4:0] OFS_SIG_FIRST = 5'h00;
    localparam logic [4:0] OFS_SIG_SECOND = 5'h01;
    localparam logic [4:0] OFS_RRC = 5'h02;
    localparam logic [4:0] OFS_CMZ = 5'h03;
    localparam logic [4:0] OFS_IO = 5'h05;
    localparam logic [4:0] OFS_BBR = 5'h19;
    localparam logic [4:0] OFS_LAST = OFS_BBR;
    // EEPROM bus addresses (plain defaults)
    localparam logic [7:0] DEV_ADDR_WR = 8'hA0;
    localparam logic [7:0] DEV_ADDR_RD = 8'hA1;
    localparam logic [7:0] WORD_ADDR_START = 8'h00;
    // Link transaction stages
    localparam logic [1:0] STG_ADDR_W = 2'h0;
    localparam logic [1:0] STG_WORD = 2'h1;
    localparam logic [1:0] STG_ADDR_R = 2'h2;
    localparam logic [1:0] STG_READ = 2'h3;
    localparam logic [3:0] BIT_ACK = 4'h8;
    // Rate recovery control byte fields
    localparam int RRC_WCLK_BIT = 7;
    localparam int RRC_FMT_HI = 6;
    localparam int RRC_FMT_LO = 5;
    localparam int RRC_PHASE_BIT = 4;
    localparam int RRC_WID_HI = 3;
    localparam int RRC_WID_LO = 2;
    localparam int RRC_STEREO_BIT = 1;
    localparam int RRC_GO_BIT = 0;
    localparam logic [1:0] WIDTH_RESERVED = 2'h0;
    // Converter mode zero byte fields, then the IO clip bit, bass boost and clipping constants
    localparam int CMZ_SEL_BIT = 7;
    localparam logic [7:0] CMZ_SEL_MASK = 8'h80;
    localparam int CMZ_TONE_HI = 6;
    localparam int CMZ_TONE_LO = 5;
    localparam int CMZ_DEEMPH_BIT = 4;
    localparam int CMZ_SWAP_BIT = 3;
    localparam int CMZ_SYNC_BIT = 2;
    localparam int CMZ_MUTE_BIT = 1;
    localparam int CMZ_RESET_BIT = 0;
    localparam logic [1:0] TONE_FLAT = 2'h0;
    localparam logic [1:0] TONE_MAX = 2'h3;
    localparam int IO_CLIP_BIT = 7;
    localparam logic [7:0] BBR_HIDDEN = 8'h00;
    localparam logic [7:0] CLIP_HEADROOM = 8'h60;
    // Built-in maps, indexed by {high pin, low pin}
    localparam logic [7:0] MAP_RRC [4] = '{8'h0B, 8'h0B, 8'h0F, 8'h8B};
    localparam logic [7:0] MAP_CMZ [4] = '{8'h00, 8'h60, 8'h10, 8'h64};
    localparam logic [7:0] MAP_IO [4] = '{8'h00, 8'h80, 8'h80, 8'h00};
    localparam logic [7:0] MAP_BBR [4] = '{8'h01, 8'h01, 8'h00, 8'h01};
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int INIT_TIME_MS = 10;
    localparam int INIT_CYCLES = INIT_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int INIT_W = 17;
    localparam int LINK_PERIOD_NS = 160;
    localparam int SCL_QUARTER_NS = 2500;
    localparam int QUARTER_CYCLES =
        (SCL_QUARTER_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam logic [3:0] QUARTER_LAST = 4'(QUARTER_CYCLES - 1);
    localparam logic [1:0] PH_SAMPLE = 2'h2;
    localparam logic [1:0] PH_LAST = 2'h3;
endpackage

/* File: startup_config_map_loader.sv */
// Start-up configuration loader: waits out internal initialisation,
// reads a configuration map from a serial EEPROM over the two-wire bus,
// or falls back to four built-in maps chosen by two select pins.
// Assumes link_clk runs free; pins are open drain, pulled up outside.
`timescale 1ns/1ns
module startup_config_map_loader
    import startup_cfg_pkg::*;
#(
    parameter int INIT_CYCLES_P = INIT_CYCLES
) (
    input wire logic clock, // Core clock, 10 MHz
    input wire logic nrst, // Synchronous reset, active low
    input wire logic link_clk, // Bus engine clock
    output logic scl_o, // Clock line level when driven
    output logic scl_oe, // Clock line pulled low
    input wire logic sda_i, // Data line level
    output logic sda_o, // Data line level when driven
    output logic sda_oe, // Data line pulled low
    input wire logic config_select_pin_high, // Map select, high bit
    input wire logic config_select_pin_low, // Map select, low bit
    input wire logic bass_boost_request_value, // Host bass boost request
    input wire logic [7:0] bass_level_request, // Host bass gain request
    input wire logic [7:0] volume_gain, // Current volume gain
    output logic config_valid, // Configuration applied
    output logic from_eeprom, // Map came from the EEPROM
    output logic [7:0] rate_recovery_control, // Applied byte 2
    output logic [7:0] converter_mode_zero, // Applied byte 3
    output logic robust_wclk_en, // Robust word clock on
    output logic [1:0] out_format, // Serial output format
    output logic mono_phase_inv, // Mono phase inversion on
    output logic [1:0] sample_width, // Sample width code
    output logic width_reserved, // Width code is reserved
    output logic stereo, // Stereo when high
    output logic rate_recovery_go, // Rate recovery running
    output logic [1:0] tone_mode, // Raw tone mode field
    output logic tone_minimum, // Tone mode is minimum
    output logic deemph_en, // De-emphasis on
    output logic chan_swap, // Left and right swapped
    output logic sync_mode, // Synchronous operation
    output logic mute, // Converter muted
    output logic converter_reset, // Converter held in reset
    output logic bass_boost_reported, // Bass boost shown to host
    output logic clip_prevent_en, // Clipping prevention on
    output logic bass_boost_on, // Bass boost switch
    output logic [7:0] bass_gain // Applied bass gain
);

    typedef enum logic [3:0] {
        L_IDLE = 4'b0001,
        L_START = 4'b0010,
        L_XFER = 4'b0100,
        L_STOP = 4'b1000
    } link_state_e;

    typedef enum logic [2:0] {
        C_INIT = 3'b001,
        C_PROBE = 3'b010,
        C_LOCKED = 3'b100
    } core_state_e;

    // Link domain state
    link_state_e l_state_q;
    logic lrst_s1, lrst_n;
    logic req_s1, req_s2, req_s3;
    logic [3:0] qcnt_q, bit_q;
    logic [1:0] ph_q, stage_q;
    logic [7:0] tx_q, rx_q;
    logic [4:0] idx_q;
    logic nack_q, restart_q, ok_q, done_tgl_q;
    logic scl_oe_q, sda_oe_q;
    logic [7:0] sig_first_q, sig_second_q, l_rrc_q, l_cmz_q, l_io_q, l_bbr_q;
    logic scl_low, sda_low;

    // Core domain state, with the link-domain sda_s1 and sda_s2
    core_state_e c_state_q;
    logic [INIT_W-1:0] init_cnt_q;
    logic req_tgl_q, done_s1, done_s2, done_s3;
    logic pin_h1, pin_h2, pin_l1, pin_l2;
    logic sda_s1, sda_s2;
    logic valid_q, from_ee_q, bb_on_q;
    logic [7:0] rrc_q, cmz_q, io_q, bbr_q, bass_q;

    // Link decode
    wire tick = (qcnt_q == QUARTER_LAST);
    wire step = tick && (ph_q == PH_LAST);
    wire sample = tick && (ph_q == PH_SAMPLE);
    wire l_go = (req_s2 ^ req_s3) && (l_state_q == L_IDLE);
    wire reading = (stage_q == STG_READ);
    wire at_ack = (bit_q == BIT_ACK);
    wire sig_bad = ((idx_q == OFS_SIG_FIRST) && (rx_q != SIG_FIRST))
        || ((idx_q == OFS_SIG_SECOND) && (rx_q != SIG_SECOND));
    wire read_end = sig_bad || (idx_q == OFS_LAST);
    wire addr_nack = sample && at_ack && !reading && sda_s2;
    // Data waits one cycle after the clock falls: hold time, no false edges
    wire sda_hold = (ph_q == '0) && (qcnt_q == '0);

    // Link reset and request synchronisers
    always_ff @(posedge link_clk) begin
        lrst_s1 <= nrst;
        lrst_n <= lrst_s1;
    end

    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
        end else begin
            req_s1 <= req_tgl_q;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
            sda_s1 <= sda_i;
            sda_s2 <= sda_s1;
        end
    end

    // Quarter-bit timer and phase
    always_ff @(posedge link_clk) begin
        if (!lrst_n || l_state_q == L_IDLE) begin
            qcnt_q <= 4'h0;
            ph_q <= 2'h0;
        end else begin
            qcnt_q <= tick ? 4'h0 : qcnt_q + 4'h1;
            ph_q <= tick ? ph_q + 2'h1 : ph_q;
        end
    end

    // Line drive per state and phase
    always_comb begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        case (l_state_q)
            L_START: begin
                scl_low = (ph_q == PH_LAST);
                sda_low = (ph_q >= PH_SAMPLE);
            end
            L_XFER: begin
                scl_low = (ph_q < PH_SAMPLE);
                if (reading)
                    sda_low = at_ack && !read_end;
                else
                    sda_low = !at_ack && !tx_q[7];
            end
            L_STOP: begin
                scl_low = (ph_q < PH_SAMPLE);
                sda_low = (ph_q != PH_LAST);
            end
            default: begin
                scl_low = 1'b0;
                sda_low = 1'b0;
            end
        endcase
    end

    // Registered open-drain enables
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else begin
            scl_oe_q <= scl_low;
            sda_oe_q <= sda_hold ? sda_oe_q : sda_low;
        end
    end

    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            l_state_q <= L_IDLE;
            stage_q <= STG_ADDR_W;
            bit_q <= 4'h0;
            idx_q <= 5'h00;
            tx_q <= 8'h00;
            restart_q <= 1'b0;
            ok_q <= 1'b0;
            done_tgl_q <= 1'b0;
        end else if (l_go) begin
            l_state_q <= L_START;
            stage_q <= STG_ADDR_W;
            tx_q <= DEV_ADDR_WR;
            ok_q <= 1'b0;
        end else if (step) begin
            case (l_state_q)
                L_START: begin
                    l_state_q <= L_XFER;
                    bit_q <= 4'h0;
                end
                L_XFER: begin
                    bit_q <= at_ack ? 4'h0 : bit_q + 4'h1;
                    if (!at_ack && !reading)
                        tx_q <= {tx_q[6:0], 1'b0};
                    if (at_ack && !reading && nack_q) begin
                        l_state_q <= L_STOP;
                        restart_q <= 1'b0;
                    end else if (at_ack && stage_q == STG_ADDR_W) begin
                        stage_q <= STG_WORD;
                        tx_q <= WORD_ADDR_START;
                    end else if (at_ack && stage_q == STG_WORD) begin
                        stage_q <= STG_ADDR_R;
                        tx_q <= DEV_ADDR_RD;
                        restart_q <= 1'b1;
                        l_state_q <= L_STOP;
                    end else if (at_ack && stage_q == STG_ADDR_R) begin
                        stage_q <= STG_READ;
                        idx_q <= 5'h00;
                    end else if (at_ack && reading) begin
                        idx_q <= idx_q + 5'h01;
                        if (read_end) begin
                            l_state_q <= L_STOP;
                            ok_q <= !sig_bad;
                        end
                    end
                end
                L_STOP: begin
                    l_state_q <= restart_q ? L_START : L_IDLE;
                    restart_q <= 1'b0;
                    done_tgl_q <= restart_q ? done_tgl_q : !done_tgl_q;
                end
                default: l_state_q <= L_IDLE;
            endcase
        end
    end

    // Bit sampling and fixed-position byte capture
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            rx_q <= 8'h00;
            nack_q <= 1'b0;
        end else if (sample && l_state_q == L_XFER) begin
            rx_q <= at_ack ? rx_q : {rx_q[6:0], sda_s2};
            nack_q <= at_ack ? sda_s2 : nack_q;
        end
    end

    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            sig_first_q <= 8'h00;
            sig_second_q <= 8'h00;
            l_rrc_q <= 8'h00;
            l_cmz_q <= 8'h00;
            l_io_q <= 8'h00;
            l_bbr_q <= 8'h00;
        end else if (step && l_state_q == L_XFER && at_ack && reading) begin
            if (idx_q == OFS_SIG_FIRST) sig_first_q <= rx_q;
            if (idx_q == OFS_SIG_SECOND) sig_second_q <= rx_q;
            if (idx_q == OFS_RRC) l_rrc_q <= rx_q;
            if (idx_q == OFS_CMZ) l_cmz_q <= rx_q;
            if (idx_q == OFS_IO) l_io_q <= rx_q;
            if (idx_q == OFS_BBR) l_bbr_q <= rx_q;
        end
    end

    // Core synchronisers for pins and the done toggle
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pin_h1 <= 1'b0;
            pin_h2 <= 1'b0;
            pin_l1 <= 1'b0;
            pin_l2 <= 1'b0;
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            done_s3 <= 1'b0;
        end else begin
            pin_h1 <= config_select_pin_high;
            pin_h2 <= pin_h1;
            pin_l1 <= config_select_pin_low;
            pin_l2 <= pin_l1;
            done_s1 <= done_tgl_q;
            done_s2 <= done_s1;
            done_s3 <= done_s2;
        end
    end

    // Map selection; link bytes are stable once done has toggled
    wire done_evt = done_s2 ^ done_s3;
    wire [1:0] pin_sel = {pin_h2, pin_l2};
    wire init_end = (init_cnt_q == INIT_W'(INIT_CYCLES_P - 1));
    wire load = (c_state_q == C_PROBE) && done_evt;
    wire [7:0] new_rrc = ok_q ? l_rrc_q : MAP_RRC[pin_sel];
    wire [7:0] new_cmz = (ok_q ? l_cmz_q : MAP_CMZ[pin_sel]) & ~CMZ_SEL_MASK;
    wire [7:0] new_io = ok_q ? l_io_q : MAP_IO[pin_sel];
    wire [7:0] new_bbr = ok_q ? l_bbr_q : MAP_BBR[pin_sel];

    always_ff @(posedge clock) begin
        if (!nrst) begin
            c_state_q <= C_INIT;
            init_cnt_q <= '0;
            req_tgl_q <= 1'b0;
        end else begin
            case (c_state_q)
                C_INIT: begin
                    init_cnt_q <= init_cnt_q + INIT_W'(1);
                    if (init_end) begin
                        req_tgl_q <= !req_tgl_q;
                        c_state_q <= C_PROBE;
                    end
                end
                C_PROBE: c_state_q <= done_evt ? C_LOCKED : C_PROBE;
                C_LOCKED: c_state_q <= C_LOCKED;
                default: c_state_q <= C_INIT;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            valid_q <= 1'b0;
            from_ee_q <= 1'b0;
            rrc_q <= 8'h00;
            cmz_q <= 8'h00;
            io_q <= 8'h00;
            bbr_q <= 8'h00;
        end else if (load) begin
            valid_q <= 1'b1;
            from_ee_q <= ok_q;
            rrc_q <= new_rrc;
            cmz_q <= new_cmz;
            io_q <= new_io;
            bbr_q <= new_bbr;
        end
    end

    wire [8:0] bass_sum = {1'b0, bass_level_request} + {1'b0, volume_gain};
    wire clips = clip_prevent_en && (bass_sum > {1'b0, CLIP_HEADROOM});
    wire [7:0] bass_room = (volume_gain >= CLIP_HEADROOM) ? 8'h00
        : CLIP_HEADROOM - volume_gain;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            bb_on_q <= 1'b0;
            bass_q <= 8'h00;
        end else begin
            bb_on_q <= valid_q && bass_boost_request_value;
            bass_q <= clips ? bass_room : bass_level_request;
        end
    end

    // Pin drive: open drain, only ever pulled low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = scl_oe_q;
    assign sda_oe = sda_oe_q;

    assign config_valid = valid_q;
    assign from_eeprom = from_ee_q;
    assign rate_recovery_control = rrc_q;
    assign robust_wclk_en = rrc_q[RRC_WCLK_BIT];
    assign out_format = rrc_q[RRC_FMT_HI:RRC_FMT_LO];
    assign mono_phase_inv = rrc_q[RRC_PHASE_BIT];
    assign sample_width = rrc_q[RRC_WID_HI:RRC_WID_LO];
    assign width_reserved = valid_q && (sample_width == WIDTH_RESERVED);
    assign stereo = rrc_q[RRC_STEREO_BIT];
    assign rate_recovery_go = valid_q && rrc_q[RRC_GO_BIT];

    assign converter_mode_zero = cmz_q;
    assign tone_mode = cmz_q[CMZ_TONE_HI:CMZ_TONE_LO];
    assign tone_minimum = (tone_mode != TONE_FLAT) && (tone_mode != TONE_MAX);
    assign deemph_en = cmz_q[CMZ_DEEMPH_BIT];
    assign chan_swap = cmz_q[CMZ_SWAP_BIT];
    assign sync_mode = cmz_q[CMZ_SYNC_BIT];
    assign mute = !valid_q || cmz_q[CMZ_MUTE_BIT];
    assign converter_reset = !valid_q || cmz_q[CMZ_RESET_BIT];
    assign bass_boost_reported = valid_q && (bbr_q != BBR_HIDDEN);
    assign clip_prevent_en = valid_q && io_q[IO_CLIP_BIT];
    assign bass_boost_on = bb_on_q;
    assign bass_gain = bass_q;

    // Checks
    AST_INIT_WAIT: assert property (
        @(posedge clock) disable iff (!nrst)
        $changed(req_tgl_q) |-> $past(init_end))
        else $error("probe started before init time");
    AST_MASTER_GO: assert property (
        @(posedge link_clk) disable iff (!lrst_n)
        l_go |=> l_state_q == L_START ##1 l_state_q == L_START)
        else $error("bus start not issued");
    AST_SIGNATURE: assert property (
        @(posedge link_clk) disable iff (!lrst_n)
        $rose(ok_q) |-> sig_first_q == SIG_FIRST && sig_second_q == SIG_SECOND)
        else $error("EEPROM accepted without signature");
    AST_EE_LOAD: assert property (@(posedge clock) disable iff (!nrst)
        load && ok_q |=> from_ee_q && rrc_q == $past(l_rrc_q))
        else $error("EEPROM map not applied");
    AST_PIN_LOAD: assert property (
        @(posedge clock) disable iff (!nrst)
        load && !ok_q |=> !from_ee_q && cmz_q == (MAP_CMZ[$past(pin_sel)]
        & ~CMZ_SEL_MASK))
        else $error("built-in map not applied");
    AST_FROZEN: assert property (@(posedge clock) disable iff (!nrst)
        valid_q |=> valid_q && $stable(rrc_q) && $stable(cmz_q)
        && $stable(bbr_q))
        else $error("configuration changed after lock");
    AST_MODE_SEL: assert property (
        @(posedge clock) disable iff (!nrst)
        valid_q |-> !converter_mode_zero[CMZ_SEL_BIT])
        else $error("mode register select bit set");
    AST_BOOST_HIDE: assert property (
        @(posedge clock) disable iff (!nrst)
        valid_q && bbr_q == BBR_HIDDEN |-> !bass_boost_reported)
        else $error("bass boost reported while hidden");
    AST_BOOST_SW: assert property (
        @(posedge clock) disable iff (!nrst)
        valid_q && bass_boost_request_value ##1 valid_q
        && bass_boost_request_value |-> bass_boost_on ##1 bass_boost_on)
        else $error("bass boost switch not following request");
    AST_CLIP: assert property (@(posedge clock) disable iff (!nrst)
        clips |=> bass_gain < $past(bass_level_request))
        else $error("bass not reduced on clipping");
    AST_NACK_ABORT: assert property (
        @(posedge link_clk) disable iff (!lrst_n)
        addr_nack ##[1:16] step |=> l_state_q == L_STOP && !ok_q)
        else $error("address nack did not abort");
    COV_EEPROM: cover property (@(posedge clock) disable iff (!nrst)
        load && ok_q);
    COV_PINS: cover property (@(posedge clock) disable iff (!nrst)
        load && !ok_q);
    COV_CLIP: cover property (@(posedge clock) disable iff (!nrst) clips);

endmodule // startup_config_map_loader

/* File: startup_config_map_loader_tb.sv */
// Bench for the start-up loader: EEPROM map, bad signature, four pin maps.
// Assumes the EEPROM model on the bus and a shortened init count.
`timescale 1ns/1ns
module startup_config_map_loader_tb;
    import startup_cfg_pkg::*;
    localparam int INIT_P = 200;
    logic clock = 0, nrst = 0, link_clk = 0, present = 0;
    logic config_select_pin_high = 0, config_select_pin_low = 0;
    logic bass_boost_request_value = 0;
    logic [7:0] bass_level_request = 0, volume_gain = 0;
    logic scl_o, scl_oe, sda_i, sda_o, sda_oe, sda_pull, config_valid;
    logic from_eeprom, robust_wclk_en, mono_phase_inv, width_reserved;
    logic stereo, rate_recovery_go, tone_minimum, deemph_en, chan_swap;
    logic sync_mode, mute, converter_reset, bass_boost_reported;
    logic clip_prevent_en, bass_boost_on;
    logic [7:0] rate_recovery_control, converter_mode_zero, bass_gain;
    logic [1:0] out_format, sample_width, tone_mode;
    int errors = 0, checks = 0, cyc = 0;
    // Two unrelated clocks; data line with pull-up
    always #50 clock = !clock;
    always #80 link_clk = !link_clk;
    assign sda_i = !(sda_oe || sda_pull);
    startup_config_map_loader #(.INIT_CYCLES_P(INIT_P)) dut_u (.clock,
        .nrst, .link_clk, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe,
        .config_select_pin_high, .config_select_pin_low,
        .bass_boost_request_value, .bass_level_request, .volume_gain,
        .config_valid, .from_eeprom, .rate_recovery_control,
        .converter_mode_zero, .robust_wclk_en, .out_format, .mono_phase_inv,
        .sample_width, .width_reserved, .stereo, .rate_recovery_go,
        .tone_mode, .tone_minimum, .deemph_en, .chan_swap, .sync_mode,
        .mute, .converter_reset, .bass_boost_reported, .clip_prevent_en,
        .bass_boost_on, .bass_gain);
    cfg_eeprom_model eeprom_u (.scl(!scl_oe), .sda(sda_i), .present,
        .sda_pull);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // One start-up: reset, init, load, decode, then host side
    task automatic run(input logic pres, input logic [1:0] sel,
            input logic [7:0] sig);
        logic [7:0] r, c, io, bb;
        logic [8:0] sum;
        logic ee;
        int n;
        ee = pres && sig == SIG_SECOND;
        eeprom_u.mem[1] = sig;
        @(posedge clock);
        nrst <= 0;
        present <= pres;
        {config_select_pin_high, config_select_pin_low} <= sel;
        bass_boost_request_value <= 1;
        bass_level_request <= 8'h40;
        volume_gain <= {2'h0, sel, 4'h0} + 8'h30;
        repeat (6) @(posedge clock);
        nrst <= 1;
        repeat (INIT_P - 1) @(posedge clock);
        #1;
        check({scl_o, scl_oe, sda_o, sda_oe, config_valid, mute,
            converter_reset}, 8'h03);
        n = 0;
        while (config_valid !== 1'b1 && n < 40000) begin
            @(posedge clock);
            n++;
        end
        #1;
        check({7'h0, config_valid}, 8'h01);
        r = ee ? eeprom_u.mem[2] : MAP_RRC[sel];
        c = ee ? eeprom_u.mem[3] & 8'h7F : MAP_CMZ[sel];
        io = ee ? eeprom_u.mem[5] : MAP_IO[sel];
        bb = ee ? eeprom_u.mem[25] : MAP_BBR[sel];
        sum = 9'(bass_level_request) + 9'(volume_gain);
        check({7'h0, from_eeprom}, {7'h0, ee});
        check(rate_recovery_control, r);
        check({robust_wclk_en, out_format, mono_phase_inv, sample_width,
            stereo, rate_recovery_go}, r);
        check({1'b0, tone_mode, deemph_en, chan_swap, sync_mode, mute,
            converter_reset}, c);
        check(converter_mode_zero, c);
        check({width_reserved, tone_minimum, bass_boost_reported,
            clip_prevent_en}, {r[3:2] == 2'h0, ^c[6:5], bb != 8'h00,
            io[7]});
        @(posedge clock);
        {config_select_pin_high, config_select_pin_low} <= ~sel;
        repeat (3) @(posedge clock);
        #1;
        check(bass_gain, io[7] && sum > 9'h060 ? (volume_gain >= 8'h60 ?
            8'h00 : 8'h60 - volume_gain) : 8'h40);
        check({7'h0, bass_boost_on}, 8'h01);
        check(rate_recovery_control, r);
        check(converter_mode_zero, c);
        @(posedge clock);
        bass_boost_request_value <= 0;
        repeat (3) @(posedge clock);
        #1;
        check({7'h0, bass_boost_on}, 8'h00);
        $display("test done: eeprom %0d select %0d", pres, sel);
    endtask
    // Main sequence
    initial begin
        #1;
        eeprom_u.mem[2] = 8'hE1;
        eeprom_u.mem[3] = 8'hBF;
        eeprom_u.mem[5] = 8'h80;
        eeprom_u.mem[25] = 8'h00;
        run(1, 2'h1, SIG_SECOND);
        run(1, 2'h2, 8'h54);
        // Second map: 8-bit width, other minimum tone code, boost shown
        eeprom_u.mem[2] = 8'h35;
        eeprom_u.mem[3] = 8'h40;
        eeprom_u.mem[5] = 8'h00;
        eeprom_u.mem[25] = 8'h07;
        run(1, 2'h3, SIG_SECOND);
        for (int i = 0; i < 4; i++)
            run(0, 2'(i), SIG_SECOND);
        results();
    end
    // Cycle ceiling against hangs
    always @(posedge clock) begin
        cyc++;
        if (cyc == 90000) begin
            errors++;
            results();
        end
    end
endmodule // startup_config_map_loader_tb
